// File: verilog/wdtp_pkg.sv
// constants, types and register map of the watchdog with prescaler
// assumes an apb master on clk and a core that pulses its instructions
// What this block does
// - watchdog counts one of rc oscillator, crystal, or system clock over 4
// - with the watchdog option off, all watchdog actions do nothing
// - crystal source only usable in internal rc plus crystal mode
// - selected clock is first divided by 256 in eight fixed stages
// - low three setup bits pick an extra ratio of 1 to 2**n
// - setup bit 3 and high nibble are plain software flags
// - instruction clock source stops counting while halted
// - overflow while running gives chip reset and sets timeout flag
// - overflow while halted gives warm reset of pc and sp only
// - reset pin low, clear instruction or halt clears the whole chain
// - clear count one: single clear instruction alone clears the watchdog
// - clear count two: both paired clear instructions needed to clear
// - rc oscillator keeps running in halt unless disabled by option
// - halt stops the system clock; rc and crystal edges still reach the watchdog
// - external rc mode drives system clock over 4 on clock out pin
// - timeout flag bit 5 set by timeout, cleared by power-up, clear, halt
// - powerdown flag bit 4 set by halt, cleared by power-up or clear
package wdtp_pkg;

	localparam int         ADDR_W      = 12;
	localparam logic [7:0] IDX_SETUP   = 8'h09;
	localparam logic [7:0] IDX_STATUS  = 8'h0a;
	localparam logic [7:0] IDX_IRQ_STS = 8'h10;
	localparam logic [7:0] IDX_IRQ_EN  = 8'h11;
	localparam logic [7:0] IDX_IRQ_CLR = 8'h12;

	localparam logic [7:0] SETUP_RST   = 8'h07;
	localparam int         SEL_LSB     = 0;
	localparam int         SEL_W       = 3;
	localparam int         PDF_BIT     = 4;
	localparam int         TO_BIT      = 5;

	localparam int         NUM_EV      = 2;
	localparam int         EV_TIMEOUT  = 0;
	localparam int         EV_WARM     = 1;

	localparam int         FIX_STAGES  = 8;
	localparam int         SEL_MAX     = 7;
	localparam int         CNT_W       = FIX_STAGES + SEL_MAX;
	localparam int         INSTR_DIV   = 4;
	localparam int         DIV_W       = $clog2(INSTR_DIV);

	typedef enum logic [1:0] {
		SRC_RC    = 2'h0,
		SRC_RTC   = 2'h1,
		SRC_INSTR = 2'h2
	} wdtp_src_t;

	typedef enum logic [1:0] {
		OSC_EXT_RC     = 2'h0,
		OSC_XTAL       = 2'h1,
		OSC_INT_RC     = 2'h2,
		OSC_INT_RC_RTC = 2'h3
	} wdtp_osc_t;

	typedef enum logic {
		ST_RUN  = 1'b0,
		ST_HALT = 1'b1
	} wdtp_halt_t;

endpackage

// File: verilog/wdtp_chain.sv
// fixed divide-by-256 stage and selectable prescaler as one counter
// assumes tick is a one-cycle pulse per source clock period
`timescale 1ns/10ps
`default_nettype none

module wdtp_chain
	import wdtp_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             tick,
	input  wire logic             clr,
	input  wire logic [SEL_W-1:0] sel,
	output logic      [CNT_W-1:0] cnt,
	output logic                  ovf
);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             ovf;
	} wdtp_chain_t;

	wdtp_chain_t r;
	wdtp_chain_t n;
	logic [CNT_W-1:0] lim;

	// one counter instead of two keeps prescaler clear in step
	always_comb begin
		n = r;
		lim = '1;
		lim = lim >> (3'h7 - sel);
		n.ovf = 1'b0;
		if (clr) begin
			n.cnt = '0;
		end else if (tick) begin
			if (r.cnt >= lim) begin
				n.cnt = '0;
				n.ovf = 1'b1;
			end else begin
				n.cnt = r.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign cnt = r.cnt;
	assign ovf = r.ovf;

endmodule // wdtp_chain

`default_nettype wire

// File: verilog/wdtp_watchdog.sv
// watchdog top: apb registers, source pick, halt control, reset outputs
// assumes core instructions arrive as one-cycle pulses on clk
`timescale 1ns/10ps
`default_nettype none

module wdtp_watchdog
	import wdtp_pkg::*;
#(
	parameter bit        WDT_EN     = 1'b1,
	parameter bit        WATCHDOG_RC_SOURCE_EN = 1'b1,
	parameter wdtp_src_t WDT_SRC    = SRC_RC,
	parameter wdtp_osc_t OSC_MODE   = OSC_INT_RC_RTC,
	parameter int        CLR_TIMES  = 1
)(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              rcOscPin,
	input  wire logic              rtcOscPin,
	input  wire logic              extResetPin_n,
	input  wire logic              singleKickInstr,
	input  wire logic              firstKickInstr,
	input  wire logic              secondKickInstr,
	input  wire logic              haltInstr,
	input  wire logic              wakeReq,
	output logic                   chipReset,
	output logic                   warmReset,
	output logic                   sysClkRun,
	output logic                   clockOutPinO,
	output logic                   clockOutPinOe,
	output logic                   timeoutFlag,
	output logic                   powerdownFlag,
	output logic                   irq
);

	localparam logic [ADDR_W-1:0] A_SETUP   = {2'h0, IDX_SETUP, 2'h0};
	localparam logic [ADDR_W-1:0] A_STATUS  = {2'h0, IDX_STATUS, 2'h0};
	localparam logic [ADDR_W-1:0] A_IRQ_STS = {2'h0, IDX_IRQ_STS, 2'h0};
	localparam logic [ADDR_W-1:0] A_IRQ_EN  = {2'h0, IDX_IRQ_EN, 2'h0};
	localparam logic [ADDR_W-1:0] A_IRQ_CLR = {2'h0, IDX_IRQ_CLR, 2'h0};

	typedef struct packed {
		logic [2:0]        rcSync;
		logic [2:0]        rtcSync;
		logic [1:0]        rstSync;
		logic [DIV_W-1:0]  instrDiv;
		logic [7:0]        setup;
		logic              to;
		logic              powerdown_flag;
		wdtp_halt_t        st;
		logic              firstSeen;
		logic              secondSeen;
		logic              chipRst;
		logic              warmRst;
		logic [NUM_EV-1:0] irqSts;
		logic [NUM_EV-1:0] irqEn;
		logic [31:0]       rdata;
		logic              slvErr;
	} wdtp_main_t;

	localparam wdtp_main_t R_RST = '{
		rcSync:     3'h0,
		rtcSync:    3'h0,
		rstSync:    2'h3,
		instrDiv:   '0,
		setup:      SETUP_RST,
		to:         1'b0,
		powerdown_flag:        1'b0,
		st:         ST_RUN,
		firstSeen:  1'b0,
		secondSeen: 1'b0,
		chipRst:    1'b0,
		warmRst:    1'b0,
		irqSts:     '0,
		irqEn:      '0,
		rdata:      32'h0,
		slvErr:     1'b0
	};

	wdtp_main_t r;
	wdtp_main_t n;

	logic             rcTick;
	logic             rtcTick;
	logic             instrTick;
	logic             wdtTick;
	logic             extRst;
	logic             kickDone;
	logic             haltGo;
	logic             chainClr;
	logic             chainOvf;
	logic [CNT_W-1:0] chainCnt;
	logic             apbSetup;
	logic             apbWr;
	logic [NUM_EV-1:0] evSet;

	// edges only after two flops; rc runs through halt by option
	assign rcTick    = WATCHDOG_RC_SOURCE_EN && r.rcSync[1] && !r.rcSync[2];
	assign rtcTick   = (OSC_MODE == OSC_INT_RC_RTC)
	                   && r.rtcSync[1] && !r.rtcSync[2];
	// system clock is stopped in halt, so this source goes quiet
	assign instrTick = (r.st == ST_RUN) && (&r.instrDiv);

	always_comb begin
		case (WDT_SRC)
			SRC_RC:    wdtTick = rcTick;
			SRC_RTC:   wdtTick = rtcTick;
			SRC_INSTR: wdtTick = instrTick;
			default:   wdtTick = 1'b0;
		endcase
	end

	assign extRst = !r.rstSync[1];
	assign haltGo = haltInstr && (r.st == ST_RUN);

	// paired clear accepts either order; a single-mode part ignores pairs
	always_comb begin
		if (!WDT_EN) begin
			kickDone = 1'b0;
		end else if (CLR_TIMES == 1) begin
			kickDone = singleKickInstr;
		end else begin
			kickDone = (r.firstSeen || firstKickInstr)
			           && (r.secondSeen || secondKickInstr);
		end
	end

	assign chainClr = extRst || kickDone || (WDT_EN && haltGo);

	wdtp_chain u_chain (
		.clk   (clk),
		.rst_n (rst_n),
		.tick  (wdtTick && WDT_EN),
		.clr   (chainClr),
		.sel   (r.setup[SEL_LSB +: SEL_W]),
		.cnt   (chainCnt),
		.ovf   (chainOvf)
	);

	assign apbSetup = psel && !penable;
	assign apbWr    = psel && penable && pwrite;

	always_comb begin
		n = r;
		evSet = '0;
		n.rcSync  = {r.rcSync[1:0], rcOscPin};
		n.rtcSync = {r.rtcSync[1:0], rtcOscPin};
		n.rstSync = {r.rstSync[0], extResetPin_n};
		n.chipRst = 1'b0;
		n.warmRst = 1'b0;
		if (r.st == ST_RUN) begin
			n.instrDiv = r.instrDiv + 1'b1;
		end

		// paired clear bookkeeping
		if (WDT_EN && CLR_TIMES == 2) begin
			if (kickDone) begin
				n.firstSeen  = 1'b0;
				n.secondSeen = 1'b0;
			end else begin
				n.firstSeen  = r.firstSeen || firstKickInstr;
				n.secondSeen = r.secondSeen || secondKickInstr;
			end
		end

		// register writes; status flags are not writable
		if (apbWr) begin
			case (paddr)
				A_SETUP:   n.setup = pwdata[7:0];
				A_IRQ_EN:  n.irqEn = pwdata[NUM_EV-1:0];
				A_IRQ_CLR: n.irqSts = r.irqSts & ~pwdata[NUM_EV-1:0];
				default:   n.setup = r.setup;
			endcase
		end

		// flag clears come before sets so that a set wins
		if (kickDone) begin
			n.to  = 1'b0;
			n.powerdown_flag = 1'b0;
		end

		case (r.st)
			ST_RUN: begin
				if (haltGo) begin
					n.st  = ST_HALT;
					n.powerdown_flag = 1'b1;
					n.to  = 1'b0;
				end
			end
			ST_HALT: begin
				if (wakeReq) begin
					n.st = ST_RUN;
				end
			end
			default: n.st = ST_RUN;
		endcase

		if (WDT_EN && chainOvf) begin
			n.to = 1'b1;
			if (r.st == ST_HALT) begin
				n.warmRst = 1'b1;
				n.st = ST_RUN;
				evSet[EV_WARM] = 1'b1;
			end else begin
				n.chipRst = 1'b1;
				n.setup = SETUP_RST;
				evSet[EV_TIMEOUT] = 1'b1;
			end
		end

		// pin reset reloads setup and leaves halt; flags stay
		if (extRst) begin
			n.setup = SETUP_RST;
			n.st = ST_RUN;
		end

		n.irqSts = n.irqSts | evSet;

		// read data latched in setup so prdata comes from a flop
		if (apbSetup) begin
			n.slvErr = 1'b0;
			case (paddr)
				A_SETUP:   n.rdata = {24'h0, r.setup};
				A_STATUS:  n.rdata = {26'h0, r.to, r.powerdown_flag, 4'h0};
				A_IRQ_STS: n.rdata = {{(32-NUM_EV){1'b0}}, r.irqSts};
				A_IRQ_EN:  n.rdata = {{(32-NUM_EV){1'b0}}, r.irqEn};
				A_IRQ_CLR: n.rdata = 32'h0;
				default: begin
					n.rdata  = 32'h0;
					n.slvErr = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= R_RST;
		end else begin
			r <= n;
		end
	end

	assign prdata        = r.rdata;
	assign pready        = psel && penable;
	assign pslverr       = psel && penable && r.slvErr;
	assign chipReset     = r.chipRst;
	assign warmReset     = r.warmRst;
	assign sysClkRun     = (r.st == ST_RUN);
	assign clockOutPinOe = (OSC_MODE == OSC_EXT_RC);
	assign clockOutPinO  = clockOutPinOe && r.instrDiv[DIV_W-1];
	assign timeoutFlag   = r.to;
	assign powerdownFlag = r.powerdown_flag;
	assign irq           = |(r.irqSts & r.irqEn);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_runOvf;
		chainOvf && WDT_EN && r.st == ST_RUN && !extRst
		|=> chipReset && timeoutFlag && !warmReset
		    && r.setup == SETUP_RST;
	endproperty
	a_runOvf: assert property (p_runOvf)
		else $error("run overflow did not give chip reset");

	property p_haltOvf;
		chainOvf && WDT_EN && r.st == ST_HALT && !extRst
		&& !(apbWr && paddr == A_SETUP)
		|=> warmReset && !chipReset && sysClkRun && timeoutFlag
		    && $stable(r.setup);
	endproperty
	a_haltOvf: assert property (p_haltOvf)
		else $error("halt overflow did not give warm reset");

	property p_clrChain;
		chainClr |=> chainCnt == '0 && !chainOvf;
	endproperty
	a_clrChain: assert property (p_clrChain)
		else $error("clear did not empty the chain");

	property p_haltFlags;
		haltGo && !(WDT_EN && chainOvf) && !kickDone && !extRst
		|=> powerdownFlag && !timeoutFlag && !sysClkRun;
	endproperty
	a_haltFlags: assert property (p_haltFlags)
		else $error("halt did not set powerdown flag");

	property p_statusWrite;
		apbWr && paddr == A_STATUS && !kickDone && !haltGo
		&& !(WDT_EN && chainOvf)
		|=> $stable(timeoutFlag) && $stable(powerdownFlag);
	endproperty
	a_statusWrite: assert property (p_statusWrite)
		else $error("status write changed a flag");

	// flag bits and select alike are kept exactly as written
	property p_setupWrite;
		apbWr && paddr == A_SETUP && !(WDT_EN && chainOvf) && !extRst
		|=> r.setup == $past(pwdata[7:0]);
	endproperty
	a_setupWrite: assert property (p_setupWrite)
		else $error("setup write not stored");

	property p_instrHalt;
		r.st == ST_HALT |-> !instrTick ##1 $stable(r.instrDiv);
	endproperty
	a_instrHalt: assert property (p_instrHalt)
		else $error("instruction clock ran in halt");

	property p_rtcGate;
		OSC_MODE != OSC_INT_RC_RTC |-> !rtcTick;
	endproperty
	a_rtcGate: assert property (p_rtcGate)
		else $error("crystal source active in wrong mode");

	property p_disabled;
		!WDT_EN |-> !chipReset && !warmReset && !kickDone;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("disabled watchdog acted");

	property p_kickFlags;
		kickDone && !(WDT_EN && chainOvf) && !haltGo
		|=> !timeoutFlag && !powerdownFlag ##1 chainCnt <= 1;
	endproperty
	a_kickFlags: assert property (p_kickFlags)
		else $error("clear did not drop flags");

	property p_clkOut;
		OSC_MODE == OSC_EXT_RC && sysClkRun && $rose(clockOutPinO)
		&& !haltGo ##1 !haltGo
		|-> clockOutPinO;
	endproperty
	a_clkOut: assert property (p_clkOut)
		else $error("clock out high phase too short");

endmodule // wdtp_watchdog

`default_nettype wire

// File: verification/wdtp_core_model.sv
// core model: turns bench requests into one-cycle instruction pulses
// assumes go is held for one cycle with op valid beside it
`timescale 1ns/10ps
`default_nettype none

module wdtp_core_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       go,
	input  wire logic [1:0] op,
	output logic            singleKickInstr,
	output logic            firstKickInstr,
	output logic            secondKickInstr,
	output logic            haltInstr
);
	// op 0 single clear, 1 paired clear, 2 first half only, 3 halt
	logic pend;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			singleKickInstr <= 1'b0;
			firstKickInstr  <= 1'b0;
			secondKickInstr <= 1'b0;
			haltInstr       <= 1'b0;
			pend            <= 1'b0;
		end else begin
			singleKickInstr <= go && op == 2'h0;
			firstKickInstr  <= go && (op == 2'h1 || op == 2'h2);
			pend            <= go && op == 2'h1;
			secondKickInstr <= pend;
			haltInstr       <= go && op == 2'h3;
		end
	end
endmodule // wdtp_core_model

`default_nettype wire

// File: verification/tb_top.sv
// bench for the watchdog: apb master, core model, rc clock stimulus
// assumes a second instance with instr source, paired clears, ext rc
`timescale 1ns/10ps
`default_nettype none

module tb_top
	import wdtp_pkg::*;
;
	logic              clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic              rcOscPin, rtcOscPin, extResetPin_n, wakeReq, go, err;
	logic [1:0]        op;
	logic [2:0]        div;
	logic              singleKickInstr, firstKickInstr, secondKickInstr;
	logic              haltInstr, chipReset, warmReset, sysClkRun;
	logic              clockOutPinO, clockOutPinOe, timeoutFlag;
	logic              powerdownFlag, irq;
	logic              chipResetB, warmResetB, timeoutFlagB;
	logic              clockOutPinOB, clockOutPinOeB;
	int                nMismatch, nTests, nChip, nWarm, cyc;
	int                nChipB, nWarmB;

	// rc source chosen over instr clock: keeps counting in halt
	wdtp_watchdog #(.WDT_SRC(SRC_RC)) wdtp_watchdog_inst (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rcOscPin(rcOscPin),
		.rtcOscPin(rtcOscPin), .extResetPin_n(extResetPin_n),
		.singleKickInstr(singleKickInstr), .firstKickInstr(firstKickInstr),
		.secondKickInstr(secondKickInstr), .haltInstr(haltInstr),
		.wakeReq(wakeReq), .chipReset(chipReset), .warmReset(warmReset),
		.sysClkRun(sysClkRun), .clockOutPinO(clockOutPinO),
		.clockOutPinOe(clockOutPinOe), .timeoutFlag(timeoutFlag),
		.powerdownFlag(powerdownFlag), .irq(irq));

	// instr source, paired clears and clock out: options the first instance leaves off
	wdtp_watchdog #(
		.WDT_SRC   (SRC_INSTR),
		.OSC_MODE  (OSC_EXT_RC),
		.CLR_TIMES (2)
	) wdtp_watchdog_inst_b (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
		.pready(), .pslverr(), .rcOscPin(rcOscPin),
		.rtcOscPin(rtcOscPin), .extResetPin_n(extResetPin_n),
		.singleKickInstr(singleKickInstr), .firstKickInstr(firstKickInstr),
		.secondKickInstr(secondKickInstr), .haltInstr(haltInstr),
		.wakeReq(wakeReq), .chipReset(chipResetB), .warmReset(warmResetB),
		.sysClkRun(), .clockOutPinO(clockOutPinOB),
		.clockOutPinOe(clockOutPinOeB), .timeoutFlag(timeoutFlagB),
		.powerdownFlag(), .irq());

	wdtp_core_model wdtp_core_model_inst (
		.clk(clk), .rst_n(rst_n), .go(go), .op(op),
		.singleKickInstr(singleKickInstr), .firstKickInstr(firstKickInstr),
		.secondKickInstr(secondKickInstr), .haltInstr(haltInstr));

	always #5 clk = ~clk;

	// rc pin period 4 clk, so one tick per 4 clk like the instr clock
	always @(posedge clk) begin
		div       <= div + 3'h1;
		rcOscPin  <= div[1];
		rtcOscPin <= div[2];
		cyc       <= cyc + 1;
		if (chipReset === 1'b1) nChip <= nChip + 1;
		if (warmReset === 1'b1) nWarm <= nWarm + 1;
		if (chipResetB === 1'b1) nChipB <= nChipB + 1;
		if (warmResetB === 1'b1) nWarmB <= nWarmB + 1;
		if (cyc == 40000) begin
			nMismatch++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (nMismatch == 0 && nTests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		nTests++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			nMismatch++;
		end
	endtask

	// held until pready is sampled high, released only after that edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic core(input logic [1:0] o);
		@(posedge clk);
		go <= 1'b1;
		op <= o;
		@(posedge clk);
		go <= 1'b0;
	endtask

	task automatic wait_ev(input bit warm, output int n);
		n = 0;
		while ((warm ? warmReset : chipReset) !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
	endtask

	task automatic t_regs();
		apb(1'b0, 12'h024, 32'h0);
		chk("setup reset", 32'h07, rd);
		apb(1'b1, 12'h024, 32'hf8);
		apb(1'b0, 12'h024, 32'h0);
		chk("setup flags", 32'hf8, rd);
		apb(1'b1, 12'h028, 32'hff);
		apb(1'b0, 12'h028, 32'h0);
		chk("status", 32'h0, rd);
		apb(1'b0, 12'h100, 32'h0);
		chk("slverr", 32'h1, err);
		chk("unmapped data", 32'h0, rd);
		chk("clkout oe", 32'h0, clockOutPinOe);
		chk("clkout", 32'h0, clockOutPinO);
	endtask

	// flag bits stay set from t_regs: timing must not move
	task automatic t_timeout();
		int n;
		core(2'h0);
		wait_ev(1'b0, n);
		chk("timeout span", 32'h1, n >= 1020 && n <= 1040);
		@(negedge clk);
		chk("timeout flag", 32'h1, timeoutFlag);
		apb(1'b0, 12'h024, 32'h0);
		chk("setup reload", 32'h07, rd);
		apb(1'b0, 12'h040, 32'h0);
		chk("irq status", 32'h1, rd);
		@(negedge clk);
		chk("irq masked", 32'h0, irq);
		apb(1'b1, 12'h044, 32'h3);
		@(negedge clk);
		chk("irq on", 32'h1, irq);
		apb(1'b1, 12'h048, 32'h1);
		@(negedge clk);
		chk("irq clr", 32'h0, irq);
	endtask

	task automatic t_kicks();
		int b;
		apb(1'b1, 12'h024, 32'h0);
		b = nChip;
		for (int k = 0; k < 5; k++) begin
			core(2'h0);
			repeat (600) @(posedge clk);
		end
		chk("kicked", b, nChip);
		core(2'h0);
		for (int k = 0; k < 3; k++) begin
			core(2'h1);
			repeat (400) @(posedge clk);
		end
		chk("pair ignored", b + 1, nChip);
		core(2'h0);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("kick clears flag", 32'h0, timeoutFlag);
	endtask

	task automatic t_halt();
		int n, c, w;
		apb(1'b1, 12'h024, 32'h0);
		c = nChip;
		w = nWarm;
		core(2'h3);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("halt clk", 32'h0, sysClkRun);
		chk("halt pdf", 32'h1, powerdownFlag);
		chk("halt flag", 32'h0, timeoutFlag);
		wait_ev(1'b1, n);
		chk("warm span", 32'h1, n >= 1015 && n <= 1040);
		@(negedge clk);
		chk("no chip reset", c, nChip);
		chk("warm count", w + 1, nWarm);
		chk("instr stops in halt", 32'h0, nWarmB);
		chk("warm flag", 32'h1, timeoutFlag);
		chk("warm pdf", 32'h1, powerdownFlag);
		apb(1'b0, 12'h024, 32'h0);
		chk("setup kept", 32'h0, rd);
		apb(1'b0, 12'h040, 32'h0);
		chk("warm irq", 32'h1, rd[EV_WARM]);
		core(2'h3);
		repeat (3) @(posedge clk);
		wakeReq <= 1'b1;
		@(posedge clk);
		wakeReq <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("wake", 32'h1, sysClkRun);
		core(2'h0);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("kick pdf", 32'h0, powerdownFlag);
	endtask

	task automatic t_ext();
		apb(1'b1, 12'h024, 32'hf8);
		@(posedge clk);
		extResetPin_n <= 1'b0;
		repeat (6) @(posedge clk);
		extResetPin_n <= 1'b1;
		repeat (4) @(posedge clk);
		apb(1'b0, 12'h024, 32'h0);
		chk("pin reset setup", 32'h07, rd);
	endtask

	// second instance: pairs clear it, a lone first half or single does not
	task automatic t_pair();
		int c, h;
		apb(1'b1, 12'h024, 32'h0);
		c = nChipB;
		for (int k = 0; k < 3; k++) begin
			core(2'h1);
			repeat (600) @(posedge clk);
		end
		chk("pair kicks", c, nChipB);
		core(2'h0);
		core(2'h2);
		repeat (1100) @(posedge clk);
		chk("half pair", c + 1, nChipB);
		chk("pair timeout flag", 32'h1, timeoutFlagB);
		chk("clkout oe pair", 32'h1, clockOutPinOeB);
		h = 0;
		repeat (8) begin
			@(negedge clk);
			h += clockOutPinOB;
		end
		chk("clkout duty", 32'h4, h);
	endtask

	initial begin
		{clk, rst_n, psel, penable, pwrite, wakeReq, go} = '0;
		{paddr, pwdata, op, div, rcOscPin, rtcOscPin} = '0;
		{nMismatch, nTests, nChip, nWarm, cyc} = '0;
		{nChipB, nWarmB} = '0;
		extResetPin_n = 1'b1;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_timeout();
		t_kicks();
		t_halt();
		t_ext();
		t_pair();
		give_verdict();
	end
endmodule // tb_top

`default_nettype wire
